// file: hw/sector_fmt_pkg.sv
// constants, tables, state types and check-code steps shared by the sector formatter
package sector_fmt_pkg;

   // framing
   localparam logic [7:0]  SYNC_BYTE   = 8'hA1;   // sync pattern, value arbitrary
   localparam logic [9:0]  PRE_MIN     = 10'h00B; // least zero bytes ahead of a sync byte
   localparam logic [9:0]  HDR_LEN     = 10'h004; // two header words
   localparam logic [9:0]  CHK_LEN     = 10'h002; // two check characters
   localparam logic [9:0]  GAP_LEN     = 10'h002; // filler after the header checks
   localparam logic [9:0]  DATA_LEN    = 10'h200; // 256 words
   localparam logic [9:0]  ECC_LEN     = 10'h004; // 32-bit code
   localparam logic [9:0]  RX_HDR_LEN  = 10'h006; // header words plus checks
   localparam logic [9:0]  RX_DATA_LEN = 10'h204; // data plus code

   // drive types: zero bytes per preamble, recovery bytes, sectors per track
   localparam logic [9:0] TYPE_PRE [2] = '{10'h010, 10'h014};
   localparam logic [9:0] TYPE_REC [2] = '{10'h004, 10'h008};
   localparam logic [7:0] TYPE_SPT [2] = '{8'h11, 8'h20};
   localparam logic [7:0] ILV_LIMIT    = 8'h17;  // at or below: two-to-one interleave

   // legacy geometry and unit map, two logical units per physical drive
   localparam logic [5:0]  LEGACY_SPT        = 6'h28;
   localparam logic [2:0]  UNIT_PHYS [8]     = '{3'h0, 3'h0, 3'h1, 3'h1,
                                                 3'h2, 3'h2, 3'h3, 3'h3};
   localparam logic [23:0] UNIT_BASE [8]     = '{24'h000000, 24'h00A000, 24'h000000,
                                                 24'h00A000, 24'h000000, 24'h00A000,
                                                 24'h000000, 24'h00A000};
   localparam logic [23:0] UNIT_SIZE         = 24'h00A000;

   // register window choices, picked by the switch bank
   localparam logic [21:0] ADDR_BASE [4] = '{22'h3FF900, 22'h3FFDC0, 22'h3FFCC0, 22'h3FFAC0};
   localparam logic [3:0]  ADDR_NREG [4] = '{4'h4, 4'h4, 4'h5, 4'h5};

   // self-test duration
   localparam int unsigned SELFTEST_NS  = 1000;
   localparam int unsigned CLK_NS       = 5;
   localparam logic [7:0]  SELFTEST_CYC = 8'((SELFTEST_NS + CLK_NS - 1) / CLK_NS);

   localparam logic [15:0] CRC16_POLY = 16'h1021;
   localparam logic [31:0] CRC32_POLY = 32'h04C11DB7;

   typedef enum logic [3:0] {
      ST_IDLE  = 4'b0000,
      ST_HPRE  = 4'b0001,
      ST_HSYNC = 4'b0010,
      ST_HDR   = 4'b0011,
      ST_HCHK  = 4'b0100,
      ST_HGAP  = 4'b0101,
      ST_DPRE  = 4'b0110,
      ST_DSYNC = 4'b0111,
      ST_DATA  = 4'b1000,
      ST_ECC   = 4'b1001,
      ST_RECOV = 4'b1010
   } fmt_state_t;

   typedef enum logic [1:0] {
      RX_HUNT  = 2'b00,
      RX_FIELD = 2'b01,
      RX_CHECK = 2'b10
   } rx_state_t;

   // msb-first check-code steps, zero start so a good field leaves zero
   function automatic logic [15:0] crc16_byte(input logic [15:0] c, input logic [7:0] d);
      logic [15:0] r;
      r = c;
      for (int i = 7; i >= 0; i--)
         r = (r[15] ^ d[i]) ? ({r[14:0], 1'b0} ^ CRC16_POLY) : {r[14:0], 1'b0};
      return r;
   endfunction

   function automatic logic [31:0] crc32_byte(input logic [31:0] c, input logic [7:0] d);
      logic [31:0] r;
      r = c;
      for (int i = 7; i >= 0; i--)
         r = (r[31] ^ d[i]) ? ({r[30:0], 1'b0} ^ CRC32_POLY) : {r[30:0], 1'b0};
      return r;
   endfunction

endpackage

// file: hw/check_if.sv
// byte feed and running check codes between the formatter and a check engine
`timescale 1ns/10ps
interface check_if;
   logic        clr;
   logic        en;
   logic [7:0]  din;
   logic [15:0] crc16;
   logic [31:0] crc32;

   modport user   (output clr, output en, output din, input crc16, input crc32);
   modport engine (input clr, input en, input din, output crc16, output crc32);
endinterface

// file: hw/sector_check.sv
// running header check and data code engine, one byte per cycle
`timescale 1ns/10ps
module sector_check
   import sector_fmt_pkg::*;
(
   input  wire logic clk_sys_i,
   input  wire logic rstn_i,
   check_if.engine   chk
);

   logic [15:0] crc16_r;
   logic [31:0] crc32_r;

   // clear wins over a byte so every field starts from zero
   always_ff @(posedge clk_sys_i)
   begin
      if (!rstn_i || chk.clr)
      begin
         crc16_r <= 16'h0000;
         crc32_r <= 32'h00000000;
      end
      else if (chk.en)
      begin
         crc16_r <= crc16_byte(crc16_r, chk.din);
         crc32_r <= crc32_byte(crc32_r, chk.din);
      end
   end

   assign chk.crc16 = crc16_r;
   assign chk.crc32 = crc32_r;

endmodule

// file: hw/disk_sector_format_mapper.sv
// sector formatter, unit mapper, header generator, sync hunter and bus-side control
// Operation
// - a host interrupt is raised on both the level-4 and the level-5 request lines together.
// - register base and register count come from a lookup table chosen by the switch bank.
// - power-good or bus initialise each alone performs a full controller clear; an interrupt event in the same cycle still raises both lines.
// - self-test runs only on the first application of power, never on a later clear.
// - cylinder, head and sector of a legacy address become one sequential 512-byte block.
// - formatting uses two-to-one interleave at 23 or fewer sectors per track, else one-to-one.
// - at most eight logical units are served, spread over at most four physical drives.
// - a logical unit never spans two physical drives; out-of-unit blocks are refused.
// - a sector holds a two-word header with two check bytes, then 256 data words and a 32-bit code.
// - correction is attempted only on the data field, never on the header.
// - each field is led by at least 11 zero bytes and an eight-bit sync byte.
// - preamble and recovery lengths are per drive type minimums, 562 bytes in the usual case.
// - a read-header request returns a header built from the current logical position.
// - the logical header is cylinder, head-select and sector, then zeros, then a check word.
// - the data field is always 512 bytes, with zero bytes padding what the source omits.
// - the sync byte marks byte boundaries on the incoming stream after a preamble.
// - a postamble recovery area follows every data field before the next sector.
`timescale 1ns/10ps
module disk_sector_format_mapper
(
   input  wire logic        clk_sys_i,
   input  wire logic        rstn_i,
   input  wire logic        dc_power_good_i,
   input  wire logic        bus_init_i,
   input  wire logic        irq_event_i,
   input  wire logic        irq_ack_i,
   input  wire logic [1:0]  addr_sw_i,
   input  wire logic        bus_addr_valid_i,
   input  wire logic [21:0] bus_addr_i,
   input  wire logic        drive_type_i,
   input  wire logic        map_req_i,
   input  wire logic        rd_hdr_req_i,
   input  wire logic [2:0]  unit_i,
   input  wire logic [8:0]  cyl_i,
   input  wire logic        head_select_bit_i,
   input  wire logic [5:0]  sec_i,
   input  wire logic        fmt_start_i,
   input  wire logic        data_valid_i,
   input  wire logic [7:0]  data_i,
   input  wire logic        rx_valid_i,
   input  wire logic [7:0]  rx_byte_i,
   input  wire logic        rx_data_field_i,
   output logic             irq_l4_o,
   output logic             irq_l5_o,
   output logic             addr_hit_o,
   output logic [3:0]       reg_idx_o,
   output logic             selftest_busy_o,
   output logic             map_valid_o,
   output logic             map_err_o,
   output logic [2:0]       phys_drive_o,
   output logic [23:0]      blk_o,
   output logic             lhdr_valid_o,
   output logic [15:0]      lhdr_w1_o,
   output logic [15:0]      lhdr_w2_o,
   output logic [15:0]      lhdr_w3_o,
   output logic             data_ready_o,
   output logic             tx_valid_o,
   output logic [7:0]       tx_byte_o,
   output logic             fmt_done_o,
   output logic             rx_sync_o,
   output logic             hdr_err_o,
   output logic             ecc_err_o,
   output logic             ecc_fix_o
);
   import sector_fmt_pkg::*;

   ////////////////////////////////////////////////////////////////////////////////
   // clear and power-up
   logic       dc_power_good_r;
   logic       pwr_seen_r;
   logic [7:0] st_cnt_r;
   logic       dc_power_good_rise;
   logic       clear;

   assign dc_power_good_rise = dc_power_good_i && !dc_power_good_r;
   assign clear     = dc_power_good_rise || bus_init_i;

   // power history survives bus initialise, so self-test cannot rerun on a clear
   always_ff @(posedge clk_sys_i)
   begin
      if (!rstn_i)
      begin
         dc_power_good_r          <= 1'b0;
         pwr_seen_r      <= 1'b0;
         st_cnt_r        <= 8'h00;
         selftest_busy_o <= 1'b0;
      end
      else
      begin
         dc_power_good_r <= dc_power_good_i;
         if (dc_power_good_rise && !pwr_seen_r)
         begin
            pwr_seen_r      <= 1'b1;
            st_cnt_r        <= SELFTEST_CYC - 8'h01;
            selftest_busy_o <= 1'b1;
         end
         else if (st_cnt_r != 8'h00)
            st_cnt_r <= st_cnt_r - 8'h01;
         else
            selftest_busy_o <= 1'b0;
      end
   end

   // both priority lines move together; a new event wins over an acknowledge
   always_ff @(posedge clk_sys_i)
   begin
      if (!rstn_i || (clear && !irq_event_i))
      begin
         irq_l4_o <= 1'b0;
         irq_l5_o <= 1'b0;
      end
      else if (irq_event_i || irq_ack_i)
      begin
         irq_l4_o <= irq_event_i;
         irq_l5_o <= irq_event_i;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // register window decode
   logic [21:0] win_off;
   assign win_off = bus_addr_i - ADDR_BASE[addr_sw_i];

   always_ff @(posedge clk_sys_i)
   begin
      if (!rstn_i)
      begin
         addr_hit_o <= 1'b0;
         reg_idx_o  <= 4'h0;
      end
      else
      begin
         addr_hit_o <= bus_addr_valid_i && (bus_addr_i >= ADDR_BASE[addr_sw_i]) &&
                       (win_off[21:1] < 21'(ADDR_NREG[addr_sw_i]));
         reg_idx_o  <= win_off[4:1];
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // unit mapping and logical header
   logic [15:0] lblk;
   logic [15:0] hdr_w1;
   logic [15:0] hcrc;

   // eight units in a fixed table, each bounded inside one drive
   assign lblk   = 16'({cyl_i, head_select_bit_i}) * 16'(LEGACY_SPT) + 16'(sec_i);
   assign hdr_w1 = {cyl_i, head_select_bit_i, sec_i};
   assign hcrc   = crc16_byte(crc16_byte(crc16_byte(crc16_byte(16'h0000, hdr_w1[15:8]),
                   hdr_w1[7:0]), 8'h00), 8'h00);

   always_ff @(posedge clk_sys_i)
   begin
      if (!rstn_i || clear)
      begin
         map_valid_o  <= 1'b0;
         map_err_o    <= 1'b0;
         phys_drive_o <= 3'h0;
         blk_o        <= 24'h000000;
      end
      else
      begin
         map_valid_o <= map_req_i;
         if (map_req_i)
         begin
            phys_drive_o <= UNIT_PHYS[unit_i];
            blk_o        <= UNIT_BASE[unit_i] + 24'(lblk);
            map_err_o    <= (24'(lblk) >= UNIT_SIZE) || (sec_i >= LEGACY_SPT);
         end
      end
   end

   // header is generated from the position, never read from the medium
   always_ff @(posedge clk_sys_i)
   begin
      if (!rstn_i || clear)
      begin
         lhdr_valid_o <= 1'b0;
         lhdr_w1_o    <= 16'h0000;
         lhdr_w2_o    <= 16'h0000;
         lhdr_w3_o    <= 16'h0000;
      end
      else
      begin
         lhdr_valid_o <= rd_hdr_req_i;
         if (rd_hdr_req_i)
         begin
            lhdr_w1_o <= hdr_w1;
            lhdr_w2_o <= 16'h0000;
            lhdr_w3_o <= hcrc;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // sector formatter
   check_if tx_chk ();
   check_if rx_chk ();

   sector_check u_tx_check (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .chk(tx_chk));
   sector_check u_rx_check (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .chk(rx_chk));

   fmt_state_t  st_r;
   fmt_state_t  st_nxt;
   logic [9:0]  cnt_r;
   logic [9:0]  fld_len;
   logic        pad_r;
   logic        pad_nxt;
   logic        type_r;
   logic [15:0] fw1_r;
   logic [7:0]  fsec_r;
   logic [7:0]  byte_nxt;
   logic [7:0]  spt;

   assign spt = TYPE_SPT[type_r];

   // field lengths per state; preamble and recovery follow the drive type
   always_comb
   begin
      fld_len = 10'h001;
      case (st_r)
         ST_HPRE, ST_DPRE: fld_len = TYPE_PRE[type_r];
         ST_HDR:           fld_len = HDR_LEN;
         ST_HCHK:          fld_len = CHK_LEN;
         ST_HGAP:          fld_len = GAP_LEN;
         ST_DATA:          fld_len = DATA_LEN;
         ST_ECC:           fld_len = ECC_LEN;
         ST_RECOV:         fld_len = TYPE_REC[type_r];
         default:          fld_len = 10'h001;
      endcase
   end

   // walk the fields in order; one byte leaves per cycle
   always_comb
   begin
      st_nxt = st_r;
      if (clear)
         st_nxt = ST_IDLE;
      else if (st_r == ST_IDLE)
         st_nxt = (fmt_start_i && !selftest_busy_o) ? ST_HPRE : ST_IDLE;
      else if (cnt_r == fld_len - 10'h001)
      begin
         case (st_r)
            ST_HPRE:  st_nxt = ST_HSYNC;
            ST_HSYNC: st_nxt = ST_HDR;
            ST_HDR:   st_nxt = ST_HCHK;
            ST_HCHK:  st_nxt = ST_HGAP;
            ST_HGAP:  st_nxt = ST_DPRE;
            ST_DPRE:  st_nxt = ST_DSYNC;
            ST_DSYNC: st_nxt = ST_DATA;
            ST_DATA:  st_nxt = ST_ECC;
            ST_ECC:   st_nxt = ST_RECOV;
            default:  st_nxt = ST_IDLE;
         endcase
      end
   end

   assign pad_nxt = (st_r == ST_IDLE) ? 1'b0 :
                    (pad_r || (st_r == ST_DATA && data_ready_o && !data_valid_i));

   // byte for the current position of the current field
   always_comb
   begin
      byte_nxt = 8'h00;
      case (st_r)
         ST_HSYNC, ST_DSYNC: byte_nxt = SYNC_BYTE;
         ST_HDR:   byte_nxt = (cnt_r[1:0] == 2'b00) ? fw1_r[15:8] :
                              (cnt_r[1:0] == 2'b01) ? fw1_r[7:0] : 8'h00;
         ST_HCHK:  byte_nxt = cnt_r[0] ? tx_chk.crc16[7:0] : tx_chk.crc16[15:8];
         ST_DATA:  byte_nxt = (pad_nxt || !data_valid_i) ? 8'h00 : data_i;
         ST_ECC:   byte_nxt = tx_chk.crc32[8'(31 - 8 * cnt_r[1:0]) -: 8];
         default:  byte_nxt = 8'h00;
      endcase
   end

   assign tx_chk.clr = (st_r == ST_HSYNC) || (st_r == ST_DSYNC);
   assign tx_chk.en  = (st_r == ST_HDR) || (st_r == ST_DATA);
   assign tx_chk.din = byte_nxt;

   always_ff @(posedge clk_sys_i)
   begin
      if (!rstn_i)
      begin
         st_r         <= ST_IDLE;
         cnt_r        <= 10'h000;
         pad_r        <= 1'b0;
         data_ready_o <= 1'b0;
         tx_valid_o   <= 1'b0;
         tx_byte_o    <= 8'h00;
         fmt_done_o   <= 1'b0;
      end
      else
      begin
         st_r         <= st_nxt;
         cnt_r        <= (st_nxt != st_r) ? 10'h000 : cnt_r + 10'h001;
         pad_r        <= pad_nxt;
         data_ready_o <= (st_nxt == ST_DATA) && !pad_nxt;
         tx_valid_o   <= (st_r != ST_IDLE) && !clear;
         tx_byte_o    <= byte_nxt;
         fmt_done_o   <= (st_r == ST_RECOV) && (st_nxt == ST_IDLE);
      end
   end

   // interleave: step two through a track of 23 or fewer sectors, then fill the odd slots; above that step one
   always_ff @(posedge clk_sys_i)
   begin
      if (!rstn_i || clear)
      begin
         type_r <= 1'b0;
         fsec_r <= 8'h00;
         fw1_r  <= 16'h0000;
      end
      else if (st_r == ST_IDLE && st_nxt == ST_HPRE)
      begin
         type_r <= drive_type_i;
         fw1_r  <= {cyl_i, head_select_bit_i, fsec_r[5:0]};
      end
      else if (st_r == ST_RECOV && st_nxt == ST_IDLE)  // with the last byte, so a held start sees it
      begin
         if (spt > ILV_LIMIT)
            fsec_r <= (fsec_r + 8'h01 >= spt) ? 8'h00 : fsec_r + 8'h01;
         else if (fsec_r + 8'h02 < spt)
            fsec_r <= fsec_r + 8'h02;
         else
            fsec_r <= fsec_r[0] ? 8'h00 : 8'h01;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // receive side: preamble and sync hunt, field check
   rx_state_t rx_st_r;
   logic [9:0] zcnt_r;
   logic [9:0] rcnt_r;
   logic       rx_is_data_r;

   assign rx_chk.clr = (rx_st_r == RX_HUNT);
   assign rx_chk.en  = (rx_st_r == RX_FIELD) && rx_valid_i;
   assign rx_chk.din = rx_byte_i;

   // header errors are only reported; only data errors start a correction
   always_ff @(posedge clk_sys_i)
   begin
      if (!rstn_i || clear)
      begin
         rx_st_r      <= RX_HUNT;
         zcnt_r       <= 10'h000;
         rcnt_r       <= 10'h000;
         rx_is_data_r <= 1'b0;
         rx_sync_o    <= 1'b0;
         hdr_err_o    <= 1'b0;
         ecc_err_o    <= 1'b0;
         ecc_fix_o    <= 1'b0;
      end
      else
      begin
         rx_sync_o <= 1'b0;
         hdr_err_o <= 1'b0;
         ecc_err_o <= 1'b0;
         ecc_fix_o <= 1'b0;
         case (rx_st_r)
            RX_HUNT:
               if (rx_valid_i)
               begin
                  if (rx_byte_i == 8'h00)
                     zcnt_r <= (zcnt_r == PRE_MIN) ? zcnt_r : zcnt_r + 10'h001;
                  else if (rx_byte_i == SYNC_BYTE && zcnt_r == PRE_MIN)
                  begin
                     rx_st_r      <= RX_FIELD;
                     rcnt_r       <= 10'h000;
                     rx_is_data_r <= rx_data_field_i;
                     rx_sync_o    <= 1'b1;
                     zcnt_r       <= 10'h000;
                  end
                  else
                     zcnt_r <= 10'h000;
               end
            RX_FIELD:
               if (rx_valid_i)
               begin
                  rcnt_r <= rcnt_r + 10'h001;
                  if (rcnt_r == (rx_is_data_r ? RX_DATA_LEN : RX_HDR_LEN) - 10'h001)
                     rx_st_r <= RX_CHECK;
               end
            RX_CHECK:
            begin
               rx_st_r <= RX_HUNT;
               if (rx_is_data_r)
               begin
                  ecc_err_o <= (rx_chk.crc32 != 32'h00000000);
                  ecc_fix_o <= (rx_chk.crc32 != 32'h00000000);
               end
               else
                  hdr_err_o <= (rx_chk.crc16 != 16'h0000);
            end
            default: rx_st_r <= RX_HUNT;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // checks
   irq_lines_pair_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
      irq_event_i |=> irq_l4_o && irq_l5_o) else $error("irq lines not raised together");
   clear_on_init_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
      bus_init_i |=> st_r == ST_IDLE && !tx_valid_o) else $error("init did not clear");
   selftest_once_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
      $rose(selftest_busy_o) |-> !$past(pwr_seen_r)) else $error("self-test rerun");
   sync_byte_out_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
      (st_r == ST_HSYNC && !clear) |=> tx_byte_o == SYNC_BYTE && tx_valid_o)
      else $error("sync byte missing");
   data_len_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
      (st_r == ST_DATA && st_nxt == ST_ECC) |-> cnt_r == 10'h1FF) else $error("data length");
   pad_zero_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
      (st_r == ST_DATA && pad_r) |=> tx_byte_o == 8'h00) else $error("pad not zero");
   no_hdr_fix_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
      ecc_fix_o |-> $past(rx_is_data_r)) else $error("header correction attempted");
   lhdr_zero_word_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
      rd_hdr_req_i && !clear |=> lhdr_valid_o && lhdr_w2_o == 16'h0000 &&
      lhdr_w1_o == $past(hdr_w1)) else $error("logical header layout");
   unit_bound_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
      (map_valid_o && !map_err_o) |-> blk_o - UNIT_BASE[$past(unit_i)] < UNIT_SIZE)
      else $error("unit crosses drive");

   fmt_done_c:   cover property (@(posedge clk_sys_i) disable iff (!rstn_i) fmt_done_o);
   rx_sync_c:    cover property (@(posedge clk_sys_i) disable iff (!rstn_i) rx_sync_o);
   data_fix_c:   cover property (@(posedge clk_sys_i) disable iff (!rstn_i) ecc_fix_o);
   selftest_c:   cover property (@(posedge clk_sys_i) disable iff (!rstn_i) $fell(selftest_busy_o));

endmodule

// file: sim/rx_stream_src.sv
// far-side byte source: one preamble and sync byte on the receive stream
`timescale 1ns/10ps
module rx_stream_src
   import sector_fmt_pkg::*;
(
   input  wire logic       clk_sys_i,
   input  wire logic       go_i,
   input  wire logic       bad_i,
   input  wire logic [9:0] len_i,
   output logic            rx_valid_o = 1'b0,
   output logic [7:0]      rx_byte_o  = 8'h00
);
   int n = 0;
   // eleven zeros, sync, then len_i zero field bytes, the last spoiled when bad_i;
   // idle bytes keep toggling so no stale value survives
   always @(posedge clk_sys_i)
   begin
      rx_valid_o <= go_i || (n != 0);
      rx_byte_o  <= (n == 11) ? SYNC_BYTE :
                    (n == 11 + len_i && bad_i) ? 8'h01 :
                    ((go_i || n != 0) ? 8'h00 : ~rx_byte_o);
      n          <= (n == 11 + len_i) ? 0 : ((go_i || n != 0) ? n + 1 : 0);
   end
endmodule

// file: sim/disk_sector_format_mapper_test.sv
// self-checking bench for the sector formatter and unit mapper
`timescale 1ns/10ps
module disk_sector_format_mapper_test;
   import sector_fmt_pkg::*;
   logic        clk_sys_i = 0, rstn_i = 0, dc_power_good_i = 0, bus_init_i = 0, go = 0, rx_bad = 0;
   logic [9:0]  rx_len = 10'h000;
   localparam logic [31:0] P16 = {CRC16_POLY, 16'h0000};  // 16-bit code run in the top half
   logic        irq_event_i = 0, irq_ack_i = 0, bus_addr_valid_i = 0, drive_type_i = 0;
   logic        map_req_i = 0, rd_hdr_req_i = 0, head_select_bit_i = 0, fmt_start_i = 0;
   logic        data_valid_i = 0, rx_valid_i, rx_data_field_i = 0;
   logic        irq_l4_o, irq_l5_o, addr_hit_o, selftest_busy_o, map_valid_o, map_err_o;
   logic        lhdr_valid_o, data_ready_o, tx_valid_o, fmt_done_o, rx_sync_o;
   logic        hdr_err_o, ecc_err_o, ecc_fix_o;
   logic [1:0]  addr_sw_i = 2'h0;
   logic [21:0] bus_addr_i = 22'h000000;
   logic [2:0]  unit_i = 3'h0, phys_drive_o;
   logic [8:0]  cyl_i = 9'h000;
   logic [5:0]  sec_i = 6'h00;
   logic [7:0]  data_i = 8'hC3, rx_byte_i, tx_byte_o;
   logic [3:0]  reg_idx_o;
   logic [23:0] blk_o;
   logic [15:0] lhdr_w1_o, lhdr_w2_o, lhdr_w3_o;
   logic [7:0]  sect [600];
   int          miscompares = 0, samples_checked = 0;

   disk_sector_format_mapper u_disk_sector_format_mapper (.*);
   rx_stream_src u_rx_stream_src (.clk_sys_i(clk_sys_i), .go_i(go), .bad_i(rx_bad),
                                  .len_i(rx_len), .rx_valid_o(rx_valid_i),
                                  .rx_byte_o(rx_byte_i));

   ////////////////////////////////////////////////////////////////////////////////////////
   // clock and watchdog; the run needs about 5000 cycles
   initial forever #2.5 clk_sys_i = ~clk_sys_i;
   initial
   begin
      repeat (10000) @(posedge clk_sys_i);
      miscompares++;
      complete_run();
   end

   // bitwise reference code, msb first
   function automatic logic [31:0] ref_crc(logic [31:0] c, logic [7:0] d, logic [31:0] p);
      for (int i = 7; i >= 0; i--)
         c = (c[31] ^ d[i]) ? ({c[30:0], 1'b0} ^ p) : {c[30:0], 1'b0};
      return c;
   endfunction

   task automatic cyc(input int n);
      repeat (n) @(negedge clk_sys_i);
   endtask

   task automatic check(input logic [47:0] seen, input logic [47:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("ERROR t=%0t seen=%0h exp=%0h", $time, seen, exp);
      end
   endtask

   task automatic complete_run();
      $display("samples_checked=%0d miscompares=%0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////////////////
   // self-test on first power-good rise only; a later rise clears pending interrupts
   task automatic t_power();
      int n = 0;
      dc_power_good_i = 1;
      cyc(2);
      check(selftest_busy_o, 1);
      while (selftest_busy_o === 1'b1 && n < 300)
      begin
         cyc(1);
         n++;
      end
      check(n >= 198 && n <= 201, 1);
      irq_event_i = 1;
      cyc(1);
      irq_event_i = 0;
      check({irq_l4_o, irq_l5_o}, 2'h3);
      dc_power_good_i = 0;
      cyc(1);
      dc_power_good_i = 1;
      cyc(2);
      check({irq_l4_o, irq_l5_o, selftest_busy_o}, 3'h0);
   endtask

   // acknowledge drops both lines; bus initialise alone clears them too
   task automatic t_irq();
      irq_event_i = 1;
      cyc(1);
      irq_event_i = 0;
      irq_ack_i = 1;
      cyc(1);
      irq_ack_i = 0;
      check({irq_l4_o, irq_l5_o}, 2'h0);
      irq_event_i = 1;
      cyc(1);
      irq_event_i = 0;
      bus_init_i = 1;
      cyc(2);
      bus_init_i = 0;
      check({irq_l4_o, irq_l5_o}, 2'h0);
   endtask

   // last register of each window hits, the word past it misses
   task automatic t_addr();
      bus_addr_valid_i = 1;
      for (int i = 0; i < 4; i++)
      begin
         addr_sw_i = 2'(i);
         bus_addr_i = ADDR_BASE[i] + 22'({ADDR_NREG[i] - 4'h1, 1'b0});
         cyc(2);
         check({addr_hit_o, reg_idx_o}, {1'b1, ADDR_NREG[i] - 4'h1});
         bus_addr_i = ADDR_BASE[i] + 22'({ADDR_NREG[i], 1'b0});
         cyc(2);
         check(addr_hit_o, 0);
      end
   endtask

   // back-to-back maps: odd unit lands in upper half, sector 40 is refused
   task automatic t_map();
      {unit_i, cyl_i, head_select_bit_i, sec_i, map_req_i} = {3'h5, 9'h003, 1'b1, 6'h07, 1'b1};
      cyc(1);
      {unit_i, sec_i} = {3'h2, 6'h28};
      check({map_valid_o, map_err_o, phys_drive_o, blk_o}, {5'h12, 24'h00A11F});
      cyc(1);
      map_req_i = 0;
      check({map_valid_o, map_err_o, phys_drive_o}, 5'h19);
   endtask

   // logical header from the requested position
   task automatic t_hdr();
      logic [31:0] c = 32'h0;
      {cyl_i, head_select_bit_i, sec_i, rd_hdr_req_i} = {9'h1A5, 1'b1, 6'h15, 1'b1};
      cyc(1);
      rd_hdr_req_i = 0;
      check({lhdr_valid_o, lhdr_w1_o, lhdr_w2_o}, {1'b1, 16'hD2D5, 16'h0000});
      for (int i = 3; i >= 0; i--)
         c = ref_crc(c, 8'(32'hD2D50000 >> 8 * i), P16);
      check(lhdr_w3_o, c[31:16]);
   endtask

   // one sector of drive type ty, nd data bytes given and the rest padded; s is its slot
   task automatic t_fmt(input logic ty, input logic [5:0] s, input int nd);
      int n = 0, k = 0, d = 0, z = 0, p = TYPE_PRE[ty], r = TYPE_REC[ty];
      logic [31:0] ch = 32'h0, cd = 32'h0;
      logic [7:0]  q = 8'h00;
      drive_type_i = ty;
      fmt_start_i = 1;
      cyc(1);
      fmt_start_i = 0;
      while (fmt_done_o !== 1'b1 && k < 700)
      begin
         cyc(1);
         k++;
         data_valid_i = data_ready_o && d < nd;
         d += data_valid_i;
         if (tx_valid_o === 1'b1)
            sect[n++] = tx_byte_o;
      end
      for (int i = 0; i < p; i++)
         z += (sect[i] !== 8'h00) + (sect[p + 9 + i] !== 8'h00);
      for (int i = 0; i < 516; i++)
      begin
         z += i < 512 && sect[2 * p + 10 + i] !== (i < nd ? 8'hC3 : 8'h00);
         cd = ref_crc(cd, sect[2 * p + 10 + i], CRC32_POLY);
         if (i < 6)
            ch = ref_crc(ch, sect[p + 1 + i], P16);
      end
      for (int i = 0; i < r; i++)
         q |= sect[2 * p + 526 + i];
      check(n, 2 * p + 526 + r);
      check({sect[p], sect[2 * p + 9], sect[p + 3], sect[p + 4]},
            {SYNC_BYTE, SYNC_BYTE, 16'h0});
      check(z, 0);
      check({ch[31:16], cd}, 0);
      check(sect[p + 2][5:0], s);
      check(q, 0);
   endtask

   // sync found after eleven zero bytes, then one zero field, its last byte spoiled when bad
   task automatic t_rx(input logic data, input logic bad);
      int k = 0;
      logic [2:0] e = 3'h0;
      rx_data_field_i = data;
      rx_bad = bad;
      rx_len = data ? RX_DATA_LEN : RX_HDR_LEN;
      go = 1;
      cyc(1);
      go = 0;
      while (rx_sync_o !== 1'b1 && k < 30)
      begin
         cyc(1);
         k++;
      end
      check({rx_sync_o, k >= 11}, 2'h3);
      repeat (530)
      begin
         cyc(1);
         e |= {hdr_err_o, ecc_err_o, ecc_fix_o};
      end
      check(e, {!data && bad, data && bad, data && bad});
   endtask

   ////////////////////////////////////////////////////////////////////////////////////////
   // main sequence
   initial
   begin
      cyc(20);
      rstn_i = 1;
      t_power();
      t_irq();
      t_addr();
      t_map();
      t_hdr();
      t_fmt(0, 6'h00, 0);
      t_fmt(0, 6'h02, 512);
      t_fmt(1, 6'h04, 100);
      t_fmt(1, 6'h05, 0);
      t_rx(0, 0);
      t_rx(0, 1);
      t_rx(1, 0);
      t_rx(1, 1);
      complete_run();
   end
endmodule
